// *** hw/etmr_regs.svh ***
// Register offsets, field positions, reset values and prescale counts
`ifndef ETMR_REGS_SVH
`define ETMR_REGS_SVH

// Register indices as printed; byte address is four times the index
`define ETMR_IDX_CTRL2     20'hfff90
`define ETMR_IDX_CTRL3     20'hfff91
`define ETMR_IDX_STATUS    20'hfff92
`define ETMR_IDX_MASK      20'hfff93
`define ETMR_ADDR_CTRL2    {10'h000, `ETMR_IDX_CTRL2, 2'b00}
`define ETMR_ADDR_CTRL3    {10'h000, `ETMR_IDX_CTRL3, 2'b00}
`define ETMR_ADDR_STATUS   {10'h000, `ETMR_IDX_STATUS, 2'b00}
`define ETMR_ADDR_MASK     {10'h000, `ETMR_IDX_MASK, 2'b00}

// Control register field positions
`define ETMR_BIT_EN_B      7
`define ETMR_BIT_EN_A      6
`define ETMR_BIT_EN_OVF    5
`define ETMR_POS_CLEAR     3
`define ETMR_POS_SOURCE    0

// Reset values
`define ETMR_RST_CTRL      8'h00
`define ETMR_RST_STATUS    6'h00
`define ETMR_RST_MASK      6'h00

// Count-source codes
`define ETMR_SRC_STOP      3'h0
`define ETMR_SRC_DIV8      3'h1
`define ETMR_SRC_DIV64     3'h2
`define ETMR_SRC_DIV8192   3'h3
`define ETMR_SRC_CASCADE   3'h4
`define ETMR_SRC_EXT_FALL  3'h5
`define ETMR_SRC_EXT_RISE  3'h6
`define ETMR_SRC_EXT_BOTH  3'h7

// Counter-clear codes
`define ETMR_CLR_NONE      2'h0
`define ETMR_CLR_MATCH_A   2'h1
`define ETMR_CLR_MATCH_B   2'h2
`define ETMR_CLR_EXTERNAL  2'h3

// Prescaler tap widths: divide by 8, 64 and 8192
`define ETMR_LOG_DIV8      3
`define ETMR_LOG_DIV64     6
`define ETMR_LOG_DIV8192   13

`endif

// *** hw/etmr_pkg.sv ***
// Types shared by the 8-bit timer control logic
package etmr_pkg;

    // One channel's control register
    typedef struct packed {
        logic       match_b_irq_enable;
        logic       match_a_irq_enable;
        logic       overflow_irq_enable;
        logic [1:0] clear_select;
        logic [2:0] count_source;
    } etmr_ctrl_t;

    // Counter events reported by the counter datapath
    typedef struct packed {
        logic match_a;
        logic match_b;
        logic overflow;
        logic capture_b;
    } etmr_evt_t;

    // Status flags held by the flag logic
    typedef struct packed {
        logic match_b_flag;
        logic match_a_flag;
        logic overflow_flag;
    } etmr_flag_t;

    // Prescaler rising-edge pulses
    typedef struct packed {
        logic div8192;
        logic div64;
        logic div8;
    } etmr_pre_t;

    // Bus data phase bookkeeping
    typedef enum logic [1:0] {
        ETMR_IDLE,
        ETMR_WRITE,
        ETMR_READ_WAIT,
        ETMR_READ_DONE
    } etmr_phase_t;

endpackage

// *** hw/etmr_channel.sv ***
// One channel: count-source select, pin filtering and clear select
`timescale 1ns/1ns
`include "etmr_regs.svh"
module etmr_channel
    import etmr_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Configuration and timing sources
    input  wire etmr_ctrl_t ctrl,
    input  wire etmr_pre_t  pre,
    input  wire logic       cascade_evt,
    input  wire etmr_evt_t  evt,
    // Pins from outside the clock domain
    input  wire logic       ext_clk_pin,
    input  wire logic       ext_clr_pin,
    // Results to the counter
    output logic            count_tick,
    output logic            count_clear
);

    // The pin filter relies on exactly three stages
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("etmr_channel needs SYNC_STAGES of 3");
    end

    logic [2:0] clk_sync_reg;      // External clock pin chain
    logic [2:0] clr_sync_reg;      // External clear pin chain
    logic       clk_level_reg;     // Accepted clock pin level
    logic       clr_level_reg;     // Accepted clear pin level
    logic       clk_agree;         // Stages two and three match
    logic       clr_agree;
    logic       ext_rise;          // Accepted rising edge
    logic       ext_fall;          // Accepted falling edge
    logic       clr_rise;          // External clear request edge
    logic       tick_next;
    logic       clear_next;

    // Stage one feeds only stage two; filter looks at two and three
    assign clk_agree = clk_sync_reg[1] == clk_sync_reg[2];
    assign clr_agree = clr_sync_reg[1] == clr_sync_reg[2];
    assign ext_rise  = clk_agree & clk_sync_reg[2] & ~clk_level_reg;
    assign ext_fall  = clk_agree & ~clk_sync_reg[2] & clk_level_reg;
    assign clr_rise  = clr_agree & clr_sync_reg[2] & ~clr_level_reg;

    // Pin synchronisers and accepted levels
    always_ff @(posedge clock) begin
        if (srst) begin
            clk_sync_reg  <= 3'h0;
            clr_sync_reg  <= 3'h0;
            clk_level_reg <= 1'b0;
            clr_level_reg <= 1'b0;
        end else begin
            clk_sync_reg  <= {clk_sync_reg[1:0], ext_clk_pin};
            clr_sync_reg  <= {clr_sync_reg[1:0], ext_clr_pin};
            clk_level_reg <= clk_agree ? clk_sync_reg[2] : clk_level_reg;
            clr_level_reg <= clr_agree ? clr_sync_reg[2] : clr_level_reg;
        end
    end

    // Count-source select, one tick per selected edge
    always_comb begin
        unique case (ctrl.count_source)
            `ETMR_SRC_STOP:     tick_next = 1'b0;
            `ETMR_SRC_DIV8:     tick_next = pre.div8;
            // divide by 64 or by 8192
            `ETMR_SRC_DIV64:    tick_next = pre.div64;
            `ETMR_SRC_DIV8192:  tick_next = pre.div8192;
            `ETMR_SRC_CASCADE:  tick_next = cascade_evt;
            `ETMR_SRC_EXT_FALL: tick_next = ext_fall;
            `ETMR_SRC_EXT_RISE: tick_next = ext_rise;
            `ETMR_SRC_EXT_BOTH: tick_next = ext_rise | ext_fall;
        endcase
    end

    // Counter clear select
    always_comb begin
        unique case (ctrl.clear_select)
            `ETMR_CLR_NONE:     clear_next = 1'b0;
            `ETMR_CLR_MATCH_A:  clear_next = evt.match_a;
            `ETMR_CLR_MATCH_B:  clear_next = evt.match_b | evt.capture_b;
            `ETMR_CLR_EXTERNAL: clear_next = clr_rise | evt.capture_b;
        endcase
    end

    // Registered outputs to the counter
    always_ff @(posedge clock) begin
        if (srst) begin
            count_tick  <= 1'b0;
            count_clear <= 1'b0;
        end else begin
            count_tick  <= tick_next;
            count_clear <= clear_next;
        end
    end

endmodule

// *** hw/etmr_ctrl.sv ***
// Control registers, prescaler and interrupt gating for two 8-bit timers
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
`include "etmr_regs.svh"
module etmr_ctrl
    import etmr_pkg::*;
#(
    parameter int PRESCALE_W = `ETMR_LOG_DIV8192
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Counter events, index 0 is channel 2, index 1 channel 3
    input  wire etmr_evt_t   evt [2],
    input  wire etmr_flag_t  flag [2],
    // External pins
    input  wire logic [1:0]  ext_clk_pin,
    input  wire logic [1:0]  ext_clr_pin,
    // Counter control
    output logic [1:0]       count_tick,
    output logic [1:0]       count_clear,
    // Interrupt requests
    output logic [1:0]       match_a_request,
    output logic [1:0]       match_b_request,
    output logic [1:0]       overflow_request,
    output logic             irq
);

    // Prescaler must cover the widest tap
    if (PRESCALE_W != `ETMR_LOG_DIV8192) begin : g_bad_pre
        $error("etmr_ctrl needs PRESCALE_W of 13");
    end

    etmr_ctrl_t              ctrl_reg [2];   // Per-channel control
    logic [5:0]              status_reg;     // Sticky request bits
    logic [5:0]              mask_reg;       // Interrupt mask
    logic [5:0]              status_next;
    logic [5:0]              req_vec;        // Current request levels
    logic [PRESCALE_W-1:0]   pre_reg;        // Free-running prescaler
    etmr_pre_t               pre;
    etmr_phase_t             phase_reg;
    logic [31:0]             addr_reg;       // Latched address phase
    logic [31:0]             rdata_mux;
    logic                    addr_valid;
    logic                    hit_ctrl2;
    logic                    hit_ctrl3;
    logic                    hit_status;
    logic                    hit_mask;
    logic                    wr_en;

    // Address phase decode, only NONSEQ/SEQ while bus ready
    assign addr_valid = hsel & htrans[1] & hready;
    assign hit_ctrl2  = addr_reg == `ETMR_ADDR_CTRL2;
    assign hit_ctrl3  = addr_reg == `ETMR_ADDR_CTRL3;
    assign hit_status = addr_reg == `ETMR_ADDR_STATUS;
    assign hit_mask   = addr_reg == `ETMR_ADDR_MASK;
    assign wr_en      = phase_reg == ETMR_WRITE;

    // Reads stall one cycle so a write just before is seen
    assign hreadyout = phase_reg != ETMR_READ_WAIT;
    assign hresp     = 1'b0;

    // Read mux; unmapped addresses read zero
    assign rdata_mux =
        hit_ctrl2  ? {24'h000000, ctrl_reg[0]} :
        hit_ctrl3  ? {24'h000000, ctrl_reg[1]} :
        hit_status ? {26'h0000000, status_reg} :
        hit_mask   ? {26'h0000000, mask_reg}   : 32'h00000000;

    // Bus phase tracking; hsize ignored, whole words only
    always_ff @(posedge clock) begin
        if (srst) begin
            phase_reg <= ETMR_IDLE;
            addr_reg  <= 32'h00000000;
        end else if (phase_reg == ETMR_READ_WAIT) begin
            phase_reg <= ETMR_READ_DONE;
        end else if (addr_valid) begin
            phase_reg <= hwrite ? ETMR_WRITE : ETMR_READ_WAIT;
            addr_reg  <= haddr;
        end else begin
            phase_reg <= ETMR_IDLE;
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            hrdata <= 32'h00000000;
        end else if (phase_reg == ETMR_READ_WAIT) begin
            hrdata <= rdata_mux;
        end
    end

    // Control and mask registers written in the data phase
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg[0] <= `ETMR_RST_CTRL;
            ctrl_reg[1] <= `ETMR_RST_CTRL;
            mask_reg    <= `ETMR_RST_MASK;
        end else if (wr_en) begin
            if (hit_ctrl2) begin
                ctrl_reg[0] <= hwdata[7:0];
            end
            if (hit_ctrl3) begin
                ctrl_reg[1] <= hwdata[7:0];
            end
            if (hit_mask) begin
                mask_reg <= hwdata[5:0];
            end
        end
    end

    // Prescaler pulses once per rising edge of each divided clock
    always_ff @(posedge clock) begin
        if (srst) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    assign pre.div8    = &pre_reg[`ETMR_LOG_DIV8-1:0];
    assign pre.div64   = &pre_reg[`ETMR_LOG_DIV64-1:0];
    assign pre.div8192 = &pre_reg[`ETMR_LOG_DIV8192-1:0];

    // Two channel instances; cascade crosses between them
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic cascade_evt;
        // ch2 takes ch3 overflow, ch3 takes ch2 match A
        assign cascade_evt = (ch == 0) ? evt[1].overflow : evt[0].match_a;

        etmr_channel #(
            .SYNC_STAGES (3)
        ) u_channel (
            .clock       (clock),
            .srst        (srst),
            .ctrl        (ctrl_reg[ch]),
            .pre         (pre),
            .cascade_evt (cascade_evt),
            .evt         (evt[ch]),
            .ext_clk_pin (ext_clk_pin[ch]),
            .ext_clr_pin (ext_clr_pin[ch]),
            .count_tick  (count_tick[ch]),
            .count_clear (count_clear[ch])
        );

        assign match_b_request[ch]  =
            flag[ch].match_b_flag & ctrl_reg[ch].match_b_irq_enable;
        assign match_a_request[ch]  =
            flag[ch].match_a_flag & ctrl_reg[ch].match_a_irq_enable;
        assign overflow_request[ch] =
            flag[ch].overflow_flag & ctrl_reg[ch].overflow_irq_enable;
        assign req_vec[3*ch +: 3]   = {match_b_request[ch],
                                       match_a_request[ch],
                                       overflow_request[ch]};
    end

    // Sticky status: a request in the clearing cycle still sets
    assign status_next = (status_reg & ~((wr_en & hit_status) ?
                         hwdata[5:0] : 6'h00)) | req_vec;

    always_ff @(posedge clock) begin
        if (srst) begin
            status_reg <= `ETMR_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq = |(status_reg & mask_reg);

    // Checks
    a_stop_no_tick: assert property (
        @(posedge clock) disable iff (srst)
        ctrl_reg[0].count_source == 3'h0 |=> !count_tick[0])
        else $error("Stopped channel produced a tick");
    a_div8_tick: assert property (
        @(posedge clock) disable iff (srst)
        ctrl_reg[1].count_source == 3'h1 && pre_reg[2:0] == 3'h7
        |=> count_tick[1])
        else $error("Divide by eight tick missing");
    // Source must stay put for both cycles, a rewrite moves the tick
    a_div64_gap: assert property (
        @(posedge clock) disable iff (srst)
        ctrl_reg[0].count_source == 3'h2 && pre_reg[5:0] == 6'h3e
        ##1 ctrl_reg[0].count_source == 3'h2
        |-> !count_tick[0] ##1 count_tick[0])
        else $error("Divide by 64 tick misplaced");
    a_div8192_tick: assert property (
        @(posedge clock) disable iff (srst)
        ctrl_reg[0].count_source == 3'h3 && pre_reg[12:0] != 13'h1fff
        |=> !count_tick[0])
        else $error("Divide by 8192 tick too early");
    a_cascade_tick: assert property (
        @(posedge clock) disable iff (srst)
        ctrl_reg[0].count_source == 3'h4 && evt[1].overflow
        |=> count_tick[0])
        else $error("Cascade overflow not counted");
    a_clear_match: assert property (
        @(posedge clock) disable iff (srst)
        ctrl_reg[1].clear_select == 2'h1 && evt[1].match_a
        |=> count_clear[1])
        else $error("Match A clear missing");
    a_never_clear: assert property (
        @(posedge clock) disable iff (srst)
        ctrl_reg[0].clear_select == 2'h0 |=> !count_clear[0])
        else $error("Clear while clearing disabled");
    a_request_sticky: assert property (
        @(posedge clock) disable iff (srst)
        match_a_request[0] |=> status_reg[1])
        else $error("Match A request not held");
    a_masked_request: assert property (
        @(posedge clock) disable iff (srst)
        !ctrl_reg[1].overflow_irq_enable ##1
        !ctrl_reg[1].overflow_irq_enable |-> !overflow_request[1])
        else $error("Disabled overflow request raised");
    a_read_stall: assert property (@(posedge clock) disable iff (srst)
        addr_valid && !hwrite && hreadyout
        |=> !hreadyout ##1 hreadyout)
        else $error("Read wait state wrong");

    c_ext_both: cover property (@(posedge clock) disable iff (srst)
        ctrl_reg[1].count_source == 3'h7 ##1 count_tick[1]);
    c_irq_raised: cover property (@(posedge clock) disable iff (srst)
        $rose(irq));
    c_ext_clear: cover property (@(posedge clock) disable iff (srst)
        ctrl_reg[0].clear_select == 2'h3 ##1 count_clear[0]);

endmodule

// *** bench/etmr_ctrl_bench.sv ***
// Self-checking bench for the two-channel 8-bit timer control block
`timescale 1ns/1ns
`include "etmr_regs.svh"
module etmr_ctrl_bench
    import etmr_pkg::*;
;
    // Clock, reset and bus
    logic        clock;
    logic        srst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    // Counter side and pins
    etmr_evt_t   evt [2];
    etmr_flag_t  flag [2];
    logic [1:0]  ext_clk_pin;
    logic [1:0]  ext_clr_pin;
    logic [1:0]  count_tick;
    logic [1:0]  count_clear;
    logic [1:0]  req_a;
    logic [1:0]  req_b;
    logic [1:0]  req_ovf;
    logic        irq;
    // Score and pulse tallies
    int          fail_count;
    int          check_count;
    int          tick_cnt [2];
    int          clr_cnt [2];
    logic [31:0] rd;

    // Single slave, so hready is its own hreadyout
    etmr_ctrl dut (
        .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .evt(evt), .flag(flag),
        .ext_clk_pin(ext_clk_pin), .ext_clr_pin(ext_clr_pin),
        .count_tick(count_tick), .count_clear(count_clear),
        .match_a_request(req_a), .match_b_request(req_b),
        .overflow_request(req_ovf), .irq(irq)
    );

    // 25 MHz clock
    initial clock = 1'b0;
    always #20 clock = ~clock;

    // Tally tick and clear pulses; scenarios compare differences
    always @(posedge clock) begin
        for (int i = 0; i < 2; i++) begin
            if (count_tick[i] === 1'b1) tick_cnt[i] <= tick_cnt[i] + 1;
            if (count_clear[i] === 1'b1) clr_cnt[i] <= clr_cnt[i] + 1;
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic check_data(input logic [31:0] got, exp, input string s);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, s,
                     got, exp);
        end
    endtask

    task automatic check_bit(input logic got, exp, input string s);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %b", $time, s, got);
        end
    endtask

    // Wait for hready at an edge; the watchdog reports a hang
    task automatic wait_ready;
        do begin
            @(posedge clock);
        end while (hreadyout !== 1'b1);
    endtask

    // One whole-word transfer, address phase then data phase
    task automatic ahb_xfer(input logic w, input logic [31:0] a, d,
                            output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask

    task automatic ahb_write(input logic [31:0] a, d);
        logic [31:0] dummy;
        ahb_xfer(1'b1, a, d, dummy);
    endtask

    task automatic ahb_read(input logic [31:0] a, output logic [31:0] r);
        ahb_xfer(1'b0, a, 32'h0, r);
    endtask

    // Reset values, read-back, upper bits and an unmapped place
    task automatic t_regs;
        ahb_read(`ETMR_ADDR_CTRL2, rd);
        check_data(rd, 32'h0, "ctrl2 reset");
        ahb_read(`ETMR_ADDR_CTRL3, rd);
        check_data(rd, 32'h0, "ctrl3 reset");
        ahb_write(`ETMR_ADDR_CTRL2, 32'hffffff3c);
        ahb_read(`ETMR_ADDR_CTRL2, rd);
        check_data(rd, 32'h3c, "ctrl2 readback");
        ahb_write(32'h003ffe50, 32'h000000ff);
        ahb_read(32'h003ffe50, rd);
        check_data(rd, 32'h0, "unmapped read");
        check_bit(hresp, 1'b0, "hresp okay");
    endtask

    // Stopped and prescaled sources; windows are whole periods
    task automatic t_sources;
        logic [2:0] code [4];
        int span [4];
        int b2;
        int b3;
        code = '{`ETMR_SRC_STOP, `ETMR_SRC_DIV8, `ETMR_SRC_DIV64,
                 `ETMR_SRC_DIV8192};
        span = '{800, 800, 1280, 16384};
        for (int k = 0; k < 4; k++) begin
            ahb_write(`ETMR_ADDR_CTRL2, {29'h0, code[k]});
            ahb_write(`ETMR_ADDR_CTRL3, {29'h0, code[k]});
            idle(20);
            b2 = tick_cnt[0];
            b3 = tick_cnt[1];
            idle(span[k]);
            check_data(tick_cnt[0] - b2, k == 0 ? 0 : span[k] >> (k == 1 ?
                3 : k == 2 ? 6 : 13), "ch2 ticks");
            check_data(tick_cnt[1] - b3, k == 0 ? 0 : span[k] >> (k == 1 ?
                3 : k == 2 ? 6 : 13), "ch3 ticks");
        end
    endtask

    // Cascade: ch2 counts ch3 overflow, ch3 counts ch2 match A
    task automatic t_cascade;
        int b2;
        int b3;
        ahb_write(`ETMR_ADDR_CTRL2, {29'h0, `ETMR_SRC_CASCADE});
        ahb_write(`ETMR_ADDR_CTRL3, {29'h0, `ETMR_SRC_CASCADE});
        for (int k = 0; k < 2; k++) begin
            idle(4);
            b2 = tick_cnt[0];
            b3 = tick_cnt[1];
            if (k == 0) evt[1].overflow <= 1'b1;
            else evt[0].match_a <= 1'b1;
            idle(1);
            evt[0] <= '0;
            evt[1] <= '0;
            idle(6);
            check_data(tick_cnt[0] - b2, k == 0, "ch2 cascade");
            check_data(tick_cnt[1] - b3, k == 1, "ch3 cascade");
        end
    endtask

    // External clock edges: fall, rise, both, on both channels
    task automatic t_external;
        int b2;
        int b3;
        for (int k = 0; k < 3; k++) begin
            ahb_write(`ETMR_ADDR_CTRL2, {29'h0, 3'(`ETMR_SRC_EXT_FALL + k)});
            ahb_write(`ETMR_ADDR_CTRL3, {29'h0, 3'(`ETMR_SRC_EXT_FALL + k)});
            idle(20);
            b2 = tick_cnt[0];
            b3 = tick_cnt[1];
            ext_clk_pin <= 2'b11;
            idle(12);
            ext_clk_pin <= 2'b00;
            idle(12);
            check_data(tick_cnt[0] - b2, k == 2 ? 2 : 1, "ch2 ext");
            check_data(tick_cnt[1] - b3, k == 2 ? 2 : 1, "ch3 ext");
        end
    endtask

    // Every clear code against every clearing cause
    task automatic t_clear;
        int b2;
        int b3;
        logic e;
        for (int c = 0; c < 4; c++) begin
            ahb_write(`ETMR_ADDR_CTRL2, {27'h0, 2'(c), 3'h0});
            ahb_write(`ETMR_ADDR_CTRL3, {27'h0, 2'(c), 3'h0});
            for (int k = 0; k < 4; k++) begin
                e = (c == 1 && k == 0) || (c == 2 && (k == 1 || k == 2)) ||
                    (c == 3 && k >= 2);
                idle(4);
                b2 = clr_cnt[0];
                b3 = clr_cnt[1];
                for (int i = 0; i < 2; i++) begin
                    evt[i].match_a   <= (k == 0);
                    evt[i].match_b   <= (k == 1);
                    evt[i].capture_b <= (k == 2);
                end
                ext_clr_pin <= {2{k == 3}};
                idle(1);
                evt[0] <= '0;
                evt[1] <= '0;
                idle(12);
                ext_clr_pin <= 2'b00;
                idle(12);
                check_data(clr_cnt[0] - b2, e, "ch2 clear");
                check_data(clr_cnt[1] - b3, e, "ch3 clear");
            end
        end
    endtask

    // Enable gating, sticky status, mask and write-one clear
    task automatic t_irq;
        flag[0] <= '1;
        flag[1] <= '1;
        for (int i = 0; i < 3; i++) begin
            ahb_write(`ETMR_ADDR_CTRL2, 32'h80 >> i);
            idle(2);
            check_bit(req_b[0], i == 0, "ch2 req b");
            check_bit(req_a[0], i == 1, "ch2 req a");
            check_bit(req_ovf[0], i == 2, "ch2 req ovf");
            check_data({29'h0, req_b[1], req_a[1], req_ovf[1]}, 32'h0,
                       "ch3 masked");
        end
        ahb_write(`ETMR_ADDR_CTRL3, 32'h40);
        idle(2);
        check_bit(req_a[1], 1'b1, "ch3 req a");
        ahb_write(`ETMR_ADDR_CTRL2, 32'h0);
        ahb_write(`ETMR_ADDR_CTRL3, 32'h0);
        flag[0] <= '0;
        flag[1] <= '0;
        ahb_read(`ETMR_ADDR_STATUS, rd);
        check_data(rd, 32'h17, "status sticky");
        check_bit(irq, 1'b0, "irq masked");
        ahb_write(`ETMR_ADDR_MASK, 32'h28);
        idle(1);
        check_bit(irq, 1'b0, "irq other bits");
        ahb_write(`ETMR_ADDR_MASK, 32'h04);
        idle(1);
        check_bit(irq, 1'b1, "irq raised");
        ahb_write(`ETMR_ADDR_STATUS, 32'h17);
        ahb_read(`ETMR_ADDR_STATUS, rd);
        check_data(rd, 32'h0, "status cleared");
        check_bit(irq, 1'b0, "irq cleared");
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial begin
        srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        evt[0] = '0; evt[1] = '0; flag[0] = '0; flag[1] = '0;
        ext_clk_pin = 2'b00; ext_clr_pin = 2'b00;
        fail_count = 0; check_count = 0;
        idle(8);
        srst <= 1'b0;
        idle(1);
        t_regs();
        t_sources();
        t_cascade();
        t_external();
        t_clear();
        t_irq();
        end_of_test();
    end

    // Watchdog well beyond the expected run of about 20000 cycles
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
endmodule
